// ==== hw/loader_pkg.sv ====
package loader_pkg;

    // ==========================================================
    // Clock and two-wire timing
    localparam int CLK_HZ      = 20_000_000;
    localparam int SCL_HZ      = 1_000_000;
    // Quarter of a bus bit, rounded up so the bus never runs fast
    localparam int QTR_CYC     = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int TIMEOUT_US  = 50_000;
    localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);

    // ==========================================================
    // Addresses and image layout
    localparam logic [7:0] EE_DEV_WR     = 8'ha0;
    localparam logic [7:0] OWN_ADDR_BASE = 8'hb0;
    localparam int         EE_AW         = 10;
    localparam logic [9:0] CFG_START     = 10'h003;
    localparam int         BYTES_PER_DEV = 37;
    localparam logic [5:0] HDR_LEN       = 6'h03;
    localparam logic [5:0] BLK_LEN       = 6'h25;
    localparam logic [5:0] HDR_BURST_IDX = 6'h02;
    localparam int         HDR_CRC_EN    = 7;
    localparam int         HDR_MAP       = 6;
    localparam int         HDR_LARGE     = 5;
    localparam int         HDR_CNT_MSB   = 3;
    localparam logic [7:0] CRC_FIXED     = 8'ha5;
    localparam logic [7:0] CRC_POLY      = 8'h07;

    // ==========================================================
    // Output swing codes reachable from pins
    localparam logic [2:0] SWING_PIN_MIN = 3'h1;
    localparam logic [2:0] SWING_PIN_MAX = 3'h6;

    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_STOP  = 2'h1,
        OP_WR    = 2'h2,
        OP_RD    = 2'h3
    } op_t;

    typedef enum logic [3:0] {
        PH_HDR  = 4'h1,
        PH_MAP  = 4'h2,
        PH_DATA = 4'h4,
        PH_CRC  = 4'h8
    } ph_t;

    typedef enum logic [10:0] {
        ST_IDLE   = 11'h001,
        ST_START  = 11'h002,
        ST_DEVW   = 11'h004,
        ST_ADDR   = 11'h008,
        ST_RSTART = 11'h010,
        ST_DEVR   = 11'h020,
        ST_READ   = 11'h040,
        ST_STOP   = 11'h080,
        ST_NEXT   = 11'h100,
        ST_DONE   = 11'h200,
        ST_FAIL   = 11'h400
    } st_t;

    // One byte step of CRC-8
    function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                             input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8_step

    // Pin level to swing code, never the two register-only codes
    function automatic logic [2:0] pin_swing(input logic [2:0] lvl);
        if (lvl < SWING_PIN_MIN) begin
            return SWING_PIN_MIN;
        end else if (lvl > SWING_PIN_MAX) begin
            return SWING_PIN_MAX;
        end
        return lvl;
    endfunction : pin_swing

endpackage : loader_pkg

// ==== hw/cfg_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

module cfg_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 37,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [DEPTH];

    // ==========================================================
    // Write port, no reset on the array
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read, zero beyond the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (32'(raddr) < DEPTH) begin
            rdata <= mem[raddr];
        end else begin
            rdata <= '0;
        end
    end

endmodule : cfg_mem

`default_nettype wire

// ==== hw/eeprom_loader.sv ====
`timescale 1ns/10ps
`default_nettype none

module eeprom_loader
    import loader_pkg::*;
#(
    parameter int TIMEOUT_CYC_P = loader_pkg::TIMEOUT_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       mode_select_pin_float,
    input  wire logic       load_grant_n,
    input  wire logic [3:0] addr_strap,
    input  wire logic [2:0] swing_pin_level,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            load_done_n,
    output logic            load_fail,
    output logic            master_active,
    output logic      [7:0] own_addr,
    output logic      [2:0] pin_swing_code,
    input  wire logic [5:0] cfg_raddr,
    output logic      [7:0] cfg_rdata
);
    import loader_pkg::*;

    localparam int QW = $clog2(QTR_CYC + 1);
    localparam logic [10:0] SYNC_RST = 11'h680;

    // ==========================================================
    // Pin synchronisers: {sda, scl, float, grant_n, strap, level}
    logic [10:0] s1_r, s2_r, s3_r, f_r, f_nxt;
    logic [7:0]  own_addr_nxt;
    logic [2:0]  swing_nxt;
    logic        sda_f, scl_f, float_f, grant_f;
    logic [3:0]  strap_f;

    // Take a bit once the second and third stage agree
    always_comb begin
        f_nxt        = (s2_r & ~(s2_r ^ s3_r)) | (f_r & (s2_r ^ s3_r));
        own_addr_nxt = OWN_ADDR_BASE + {3'h0, f_r[6:3], 1'b0};
        swing_nxt    = pin_swing(f_r[2:0]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r           <= SYNC_RST;
            s2_r           <= SYNC_RST;
            s3_r           <= SYNC_RST;
            f_r            <= SYNC_RST;
            own_addr       <= OWN_ADDR_BASE;
            pin_swing_code <= SWING_PIN_MIN;
        end else begin
            s1_r <= {sda_i, scl_i, mode_select_pin_float, load_grant_n,
                     addr_strap, swing_pin_level};
            s2_r           <= s1_r;
            s3_r           <= s2_r;
            f_r            <= f_nxt;
            own_addr       <= own_addr_nxt;
            pin_swing_code <= swing_nxt;
        end
    end

    assign sda_f   = f_r[10];
    assign scl_f   = f_r[9];
    assign float_f = f_r[8];
    assign grant_f = f_r[7];
    assign strap_f = f_r[6:3];

    // ==========================================================
    // Bit engine: four quarters per bus bit
    op_t         e_op_r, e_op_nxt, go_op;
    logic        e_busy_r, e_busy_nxt, e_ack_r, e_ack_nxt, e_done;
    logic        e_nack_r, e_nack_nxt, e_go, go_ack;
    logic [1:0]  e_q_r, e_q_nxt;
    logic [QW-1:0] e_cnt_r, e_cnt_nxt;
    logic [3:0]  e_bit_r, e_bit_nxt;
    logic [7:0]  e_sh_r, e_sh_nxt, go_byte;
    logic        scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
    logic        data_op;

    always_comb begin
        e_busy_nxt  = e_busy_r;
        e_op_nxt    = e_op_r;
        e_q_nxt     = e_q_r;
        e_cnt_nxt   = e_cnt_r;
        e_bit_nxt   = e_bit_r;
        e_sh_nxt    = e_sh_r;
        e_ack_nxt   = e_ack_r;
        e_nack_nxt  = e_nack_r;
        e_done      = 1'b0;
        scl_low_nxt = scl_low_r;
        sda_low_nxt = sda_low_r;
        data_op     = (e_op_r == OP_WR) || (e_op_r == OP_RD);
        if (!e_busy_r) begin
            if (e_go) begin
                e_busy_nxt = 1'b1;
                e_op_nxt   = go_op;
                e_sh_nxt   = go_byte;
                e_ack_nxt  = go_ack;
                e_q_nxt    = 2'h0;
                e_cnt_nxt  = '0;
                e_bit_nxt  = 4'h0;
            end
        end else begin
            case (e_op_r)
                OP_START: begin
                    scl_low_nxt = (e_q_r == 2'h0) || (e_q_r == 2'h3);
                    sda_low_nxt = e_q_r[1];
                end
                OP_STOP: begin
                    scl_low_nxt = (e_q_r == 2'h0);
                    sda_low_nxt = !e_q_r[1];
                end
                OP_WR: begin
                    scl_low_nxt = !e_q_r[1];
                    sda_low_nxt = (e_bit_r < 4'h8) && !e_sh_r[7];
                end
                default: begin
                    scl_low_nxt = !e_q_r[1];
                    sda_low_nxt = (e_bit_r == 4'h8) && e_ack_r;
                end
            endcase
            // Hold the high phase while a slave stretches the clock
            if (data_op && e_q_r == 2'h3 && !scl_f) begin
                e_cnt_nxt = e_cnt_r;
            end else if (e_cnt_r == QW'(QTR_CYC - 1)) begin
                e_cnt_nxt = '0;
                e_q_nxt   = e_q_r + 2'h1;
                if (e_q_r == 2'h3) begin
                    if (e_bit_r == 4'h8) begin
                        e_nack_nxt = sda_f;
                    end else if (e_op_r == OP_RD) begin
                        e_sh_nxt = {e_sh_r[6:0], sda_f};
                    end else begin
                        e_sh_nxt = {e_sh_r[6:0], 1'b0};
                    end
                    if (!data_op || e_bit_r == 4'h8) begin
                        e_busy_nxt = 1'b0;
                        e_done     = 1'b1;
                    end else begin
                        e_bit_nxt = e_bit_r + 4'h1;
                    end
                end
            end else begin
                e_cnt_nxt = e_cnt_r + QW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            e_busy_r  <= 1'b0;
            e_op_r    <= OP_STOP;
            e_q_r     <= 2'h0;
            e_cnt_r   <= '0;
            e_bit_r   <= 4'h0;
            e_sh_r    <= 8'h00;
            e_ack_r   <= 1'b0;
            e_nack_r  <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else begin
            e_busy_r  <= e_busy_nxt;
            e_op_r    <= e_op_nxt;
            e_q_r     <= e_q_nxt;
            e_cnt_r   <= e_cnt_nxt;
            e_bit_r   <= e_bit_nxt;
            e_sh_r    <= e_sh_nxt;
            e_ack_r   <= e_ack_nxt;
            e_nack_r  <= e_nack_nxt;
            scl_low_r <= scl_low_nxt;
            sda_low_r <= sda_low_nxt;
        end
    end

    // ==========================================================
    // Load sequencer
    st_t         st_r, st_nxt;
    ph_t         ph_r, ph_nxt;
    logic        iss_r, iss_nxt, mem_we, loading;
    logic [9:0]  cur_r, cur_nxt;
    logic [5:0]  remain_r, remain_nxt, idx_r, idx_nxt;
    logic [7:0]  burst_r, burst_nxt, hdr0_r, hdr0_nxt, hdr2_r, hdr2_nxt;
    logic [7:0]  map0_r, map0_nxt, map1_r, map1_nxt;
    logic [7:0]  crc_r, crc_nxt, crc_rx_r, crc_rx_nxt;
    logic [31:0] tmo_r, tmo_nxt;

    assign loading = !(st_r inside {ST_IDLE, ST_DONE, ST_FAIL});
    assign e_go = !e_busy_r && !iss_r &&
                  (st_r inside {ST_START, ST_DEVW, ST_ADDR, ST_RSTART,
                                ST_DEVR, ST_READ, ST_STOP});

    // Operation and byte for the current step
    always_comb begin
        go_op   = OP_WR;
        go_byte = 8'h00;
        go_ack  = (remain_r > 6'h01) &&
                  (hdr2_r == 8'h00 || {1'b0, burst_r} + 9'h001 <
                   {1'b0, hdr2_r});
        case (st_r)
            ST_START, ST_RSTART: go_op = OP_START;
            ST_STOP:             go_op = OP_STOP;
            ST_READ:             go_op = OP_RD;
            ST_DEVW: go_byte = EE_DEV_WR | {5'h00, cur_r[9:8], 1'b0};
            ST_DEVR: go_byte = EE_DEV_WR | {5'h00, cur_r[9:8], 1'b1};
            ST_ADDR: go_byte = cur_r[7:0];
            default: go_op = OP_WR;
        endcase
    end

    always_comb begin
        st_nxt     = st_r;
        ph_nxt     = ph_r;
        iss_nxt    = e_go ? 1'b1 : (e_done ? 1'b0 : iss_r);
        cur_nxt    = cur_r;
        remain_nxt = remain_r;
        idx_nxt    = idx_r;
        burst_nxt  = burst_r;
        hdr0_nxt   = hdr0_r;
        hdr2_nxt   = hdr2_r;
        map0_nxt   = map0_r;
        map1_nxt   = map1_r;
        crc_nxt    = crc_r;
        crc_rx_nxt = crc_rx_r;
        mem_we     = 1'b0;
        tmo_nxt    = loading ? tmo_r + 32'h1 : 32'h0;
        case (st_r)
            ST_IDLE: if (float_f && !grant_f) begin
                st_nxt     = ST_START;
                ph_nxt     = PH_HDR;
                cur_nxt    = 10'h000;
                remain_nxt = HDR_LEN;
                idx_nxt    = 6'h00;
            end
            ST_START: if (e_done) begin
                st_nxt    = ST_DEVW;
                burst_nxt = 8'h00;
            end
            ST_DEVW:   if (e_done) st_nxt = e_nack_nxt ? ST_STOP : ST_ADDR;
            ST_ADDR:   if (e_done) st_nxt = e_nack_nxt ? ST_STOP : ST_RSTART;
            ST_RSTART: if (e_done) st_nxt = ST_DEVR;
            ST_DEVR:   if (e_done) st_nxt = e_nack_nxt ? ST_STOP : ST_READ;
            ST_READ: if (e_done) begin
                st_nxt     = e_ack_r ? ST_READ : ST_STOP;
                cur_nxt    = cur_r + 10'h001;
                remain_nxt = remain_r - 6'h01;
                idx_nxt    = idx_r + 6'h01;
                burst_nxt  = burst_r + 8'h01;
                case (ph_r)
                    PH_HDR: begin
                        if (idx_r == 6'h00) hdr0_nxt = e_sh_nxt;
                        if (idx_r == HDR_BURST_IDX) hdr2_nxt = e_sh_nxt;
                    end
                    PH_MAP: begin
                        if (idx_r == 6'h00) map0_nxt = e_sh_nxt;
                        else map1_nxt = e_sh_nxt;
                    end
                    PH_DATA: begin
                        mem_we  = 1'b1;
                        crc_nxt = crc8_step(crc_r, e_sh_nxt);
                    end
                    default: crc_rx_nxt = e_sh_nxt;
                endcase
            end
            ST_STOP: if (e_done) st_nxt = ST_NEXT;
            ST_NEXT: begin
                st_nxt = ST_START;
                idx_nxt = (remain_r == 6'h00) ? 6'h00 : idx_r;
                if (remain_r == 6'h00) begin
                    case (ph_r)
                        PH_HDR: if (hdr0_r[HDR_CNT_MSB:0] != 4'h0 &&
                                    strap_f >= hdr0_r[HDR_CNT_MSB:0]) begin
                            st_nxt = ST_FAIL;
                        end else if (hdr0_r[HDR_MAP]) begin
                            ph_nxt = PH_MAP;
                            cur_nxt = CFG_START + (hdr0_r[HDR_LARGE] ?
                                      {5'h00, strap_f, 1'b0} :
                                      {6'h00, strap_f});
                            remain_nxt = hdr0_r[HDR_LARGE] ? 6'h02 : 6'h01;
                        end else begin
                            ph_nxt = PH_DATA;
                            cur_nxt = CFG_START +
                                10'(32'(strap_f) * BYTES_PER_DEV);
                            remain_nxt = BLK_LEN;
                            crc_nxt    = 8'h00;
                        end
                        PH_MAP: begin
                            ph_nxt  = PH_DATA;
                            cur_nxt = hdr0_r[HDR_LARGE] ?
                                      {map0_r[1:0], map1_r} :
                                      {2'h0, map0_r};
                            remain_nxt = BLK_LEN;
                            crc_nxt    = 8'h00;
                        end
                        PH_DATA: begin
                            ph_nxt     = PH_CRC;
                            remain_nxt = 6'h01;
                        end
                        default: begin
                            if (hdr0_r[HDR_CRC_EN] ? crc_rx_r == crc_r :
                                crc_rx_r == CRC_FIXED) begin
                                st_nxt = ST_DONE;
                            end else begin
                                st_nxt = ST_FAIL;
                            end
                        end
                    endcase
                end
            end
            ST_DONE: st_nxt = ST_DONE;
            ST_FAIL: st_nxt = ST_FAIL;
            default: st_nxt = ST_IDLE;
        endcase
        // A load still running after TIMEOUT_CYC_P cycles, such as one whose EEPROM never acks its device byte, ends in ST_FAIL
        if (loading && tmo_r == 32'(TIMEOUT_CYC_P - 1)) begin
            st_nxt = ST_FAIL;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= ST_IDLE;
            ph_r     <= PH_HDR;
            iss_r    <= 1'b0;
            cur_r    <= 10'h000;
            remain_r <= 6'h00;
            idx_r    <= 6'h00;
            burst_r  <= 8'h00;
            hdr0_r   <= 8'h00;
            hdr2_r   <= 8'h00;
            map0_r   <= 8'h00;
            map1_r   <= 8'h00;
            crc_r    <= 8'h00;
            crc_rx_r <= 8'h00;
            tmo_r    <= 32'h0;
        end else begin
            st_r     <= st_nxt;
            ph_r     <= ph_nxt;
            iss_r    <= iss_nxt;
            cur_r    <= cur_nxt;
            remain_r <= remain_nxt;
            idx_r    <= idx_nxt;
            burst_r  <= burst_nxt;
            hdr0_r   <= hdr0_nxt;
            hdr2_r   <= hdr2_nxt;
            map0_r   <= map0_nxt;
            map1_r   <= map1_nxt;
            crc_r    <= crc_nxt;
            crc_rx_r <= crc_rx_nxt;
            tmo_r    <= tmo_nxt;
        end
    end

    // Open-drain drive, released outside a load
    assign scl_o         = 1'b0;
    assign sda_o         = 1'b0;
    assign scl_oe        = scl_low_r && loading;
    assign sda_oe        = sda_low_r && loading;
    assign load_done_n   = (st_r != ST_DONE);
    assign load_fail     = (st_r == ST_FAIL);
    assign master_active = loading;

    cfg_mem #(.W(8), .DEPTH(BYTES_PER_DEV), .AW(6)) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (mem_we),
        .waddr (idx_r),
        .wdata (e_sh_nxt),
        .raddr (cfg_raddr),
        .rdata (cfg_rdata)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RELEASE: assert property (
        st_r == ST_DONE |-> !scl_oe && !sda_oe)
        else $error("bus still driven after load");
    AST_START_GATE: assert property (
        $rose(master_active) |-> $past(float_f) && !$past(grant_f))
        else $error("load started without float and grant");
    AST_IDLE_HOLD: assert property (
        st_r == ST_IDLE && !float_f |=> st_r == ST_IDLE)
        else $error("left idle with strap driven");
    AST_EE_ADDR: assert property (
        e_go && st_r == ST_DEVW |-> go_byte[7:3] == 5'h14 && !go_byte[0])
        else $error("wrong eeprom address byte");
    AST_OWN_ADDR: assert property (
        $stable(strap_f) |=>
        own_addr == 8'hb0 + {3'h0, $past(strap_f), 1'b0})
        else $error("own address does not follow strap");
    AST_BLOCK_LEN: assert property (
        ph_r == PH_CRC && $past(ph_r) == PH_DATA |-> $past(idx_r) == 6'h25)
        else $error("block length not 37");
    AST_FIXED_CRC: assert property (
        st_r == ST_NEXT && ph_r == PH_CRC && remain_r == 6'h00 &&
        !hdr0_r[HDR_CRC_EN] && crc_rx_r != 8'ha5 |=> st_r == ST_FAIL)
        else $error("bad fixed pattern accepted");
    AST_TIMEOUT: assert property (
        loading && tmo_r == 32'(TIMEOUT_CYC_P - 1) |=> st_r == ST_FAIL)
        else $error("timeout did not fail the load");
    AST_DONE_SRC: assert property (
        $fell(load_done_n) |-> $past(st_r) == ST_NEXT &&
        $past(ph_r) == PH_CRC)
        else $error("done without crc step");
    AST_DIRECT: assert property (
        st_r == ST_NEXT && ph_r == PH_HDR && remain_r == 6'h00 &&
        !hdr0_r[HDR_MAP] |=> st_r == ST_FAIL ||
        cur_r == 10'h003 + 10'(32'($past(strap_f)) * 37))
        else $error("direct block start wrong");
    AST_SWING: assert property (
        pin_swing_code != 3'h0 && pin_swing_code != 3'h7)
        else $error("register-only swing code on pins");

endmodule : eeprom_loader

`default_nettype wire

// ==== bench/ee_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Serial EEPROM answering random reads
module ee_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      pull
);
    logic [7:0] mem [1024]; // Up to 1024 bytes
    logic [7:0] sh;
    logic [9:0] a;
    int         bc;
    int         st;
    initial begin
        pull = 1'b0;
        bc = 0;
        st = 4;
    end
    // Start restarts framing; a fall on the clock's own edge is not one
    always @(negedge sda) begin
        #1;
        if (scl) begin
            bc = 0;
            st = 0;
        end
    end
    // Sample on rising clock
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        bc++;
    end
    // Drive on falling clock at any bus rate
    always @(negedge scl) begin
        pull = 1'b0;
        if (bc == 9) begin
            bc = 0;
            if (st == 5) st = 2;
            else if (st == 2) begin
                st = sh[0] ? 4 : 2;
                a++;
            end
        end
        // Only device bytes 0xA0 to 0xA7 are acked
        if (bc == 8 && st == 0 && sh[7:3] == 5'h14) begin
            a[9:8] = sh[2:1];
            st = sh[0] ? 5 : 1;
            pull = 1'b1;
        end else if (bc == 8 && st == 1) begin
            a[7:0] = sh;
            st = 3;
            pull = 1'b1;
        end
        if (st == 2 && bc < 8) pull = !mem[a][7-bc];
    end
endmodule : ee_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Loader bench
module tb_top;
    logic            clk;
    logic            rst_n;
    logic            flt;
    logic            grant_n;
    logic [3:0]      strap;
    logic [2:0]      lvl;
    logic [5:0]      raddr;
    logic            ee_on;
    int              failures;
    int              total_checks;
    wire logic       scl_oe;
    wire logic       sda_oe;
    wire logic       pull;
    wire logic       done_n;
    wire logic       fail;
    wire logic       mact;
    wire logic [7:0] oa;
    wire logic [7:0] rdata;
    wire logic [2:0] swc;
    wire logic       scl = !scl_oe; // Pulled-up lines
    wire logic       sda = !(sda_oe | (pull & ee_on));
    eeprom_loader #(.TIMEOUT_CYC_P(20000)) u_eeprom_loader (
        .clk(clk), .rst_n(rst_n), .mode_select_pin_float(flt),
        .load_grant_n(grant_n), .addr_strap(strap),
        .swing_pin_level(lvl), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .load_done_n(done_n),
        .load_fail(fail), .master_active(mact), .own_addr(oa),
        .pin_swing_code(swc), .cfg_raddr(raddr), .cfg_rdata(rdata));
    ee_model u_ee_model (.scl(scl), .sda(sda), .pull(pull));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    function automatic logic [7:0] crc(input logic [7:0] c, d);
        logic [7:0] x;
        x = c ^ d;
        repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction : crc
    // Image: header, 37 bytes at s, check byte after them
    task automatic img(input logic [7:0] h, input int s, input logic ok);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 1024; i++) u_ee_model.mem[i] = 8'hff;
        u_ee_model.mem[0] = h;
        u_ee_model.mem[2] = 8'h05;
        for (int i = 0; i < 37; i++) begin
            u_ee_model.mem[s+i] = 8'(i * 7 + s);
            c = crc(c, 8'(i * 7 + s));
        end
        u_ee_model.mem[s+37] = h[7] ? c : 8'ha5 ^ {7'h0, !ok};
    endtask : img
    // Reset, then wait for done or fail
    task automatic load(input int n, input int cyc);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < cyc && done_n === 1'b1 && fail === 1'b0; i++)
            @(negedge clk);
        $display("test %0d done", n);
    endtask : load
    task automatic blk(input int s);
        for (int i = 0; i < 38; i++) begin
            raddr = 6'(i);
            @(negedge clk);
            chk(rdata, i < 37 ? 8'(i * 7 + s) : 8'h00);
        end
    endtask : blk
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #4000000;
        failures++;
        final_report;
    end
    initial begin
        {flt, grant_n, strap, lvl, raddr, rst_n} = 16'h0400;
        ee_on = 1'b1;
        failures = 0;
        total_checks = 0;
        img(8'h02, 40, 1'b1);
        load(1, 200);
        chk(mact, 1'b0);
        flt = 1'b1;
        grant_n = 1'b1;
        load(2, 200);
        chk(mact, 1'b0);
        for (int v = 0; v < 8; v++) begin
            lvl = 3'(v);
            repeat (8) @(negedge clk);
            chk(swc, v == 0 ? 1 : v == 7 ? 6 : v);
        end
        $display("test swing done");
        grant_n = 1'b0;
        load(3, 30000);
        chk({done_n, fail, mact, scl_oe, sda_oe}, 5'h00);
        chk(oa, 8'hb2);
        blk(40);
        img(8'he2, 300, 1'b1);
        u_ee_model.mem[5] = 8'h01;
        u_ee_model.mem[6] = 8'h2c;
        load(4, 30000);
        chk({done_n, fail}, 2'h0);
        blk(300);
        img(8'h42, 128, 1'b0);
        u_ee_model.mem[4] = 8'h80;
        load(5, 30000);
        chk({done_n, fail, sda_oe}, 3'h6);
        blk(128);
        ee_on = 1'b0;
        load(6, 25000);
        chk({done_n, fail, mact, scl_oe, sda_oe}, 5'h18);
        final_report;
    end
endmodule : tb_top
`default_nettype wire
